// ### rtl/lin_node_mode_and_reset_control.sv
// Mode, reset and transceiver digital control of a LIN slave node
// Function
// - Supply undervoltage enters power-on-reset state
// - Supply recovery leaves reset, starts regulator init
// - Undervoltage in sleep ends in normal mode
// - Overtemperature: regulator off, reset, bus recessive
// - Cooling down reruns init regardless of pins
// - Thermal shutdown ignores local and remote wake
// - No transmit in sleep, shutdown, master reset
// - Bus level to receive output, spikes filtered
// - Transmit low drives bus dominant
// - Unconnected transmit input counts as high
// - Receive switches with comparator hysteresis
// - Reset released after output good 100 ms
// - Reset asserted after reaction delay, transients filtered
// - Bus driver active only above enable threshold
// - Power-up goes to normal regardless of enable
// - Outside undervoltage and overtemperature, regulator off only by enable high-then-low
// - Enable falling edge enters sleep
// - Sleep entry abandons any dominant transmission
// - Sleep left by bus activity when enable low
// - Enable held high keeps normal mode
// - Sleep: regulator off, bus recessive
`timescale 1ns/1ps
`include "lin_node_map.svh"

module lin_node_mode_and_reset_control #(
	parameter int RESET_DELAY_CYCLES = `LN_RESET_DELAY_CYCLES,
	parameter int RESET_REACTION_CYCLES = `LN_RESET_REACTION_CYCLES,
	parameter int RX_FILTER_CYCLES = `LN_RX_FILTER_CYCLES,
	parameter int WAKE_CYCLES = `LN_WAKE_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Analog condition flags
	input wire lin_node_pkg::supply_flags_t flags,
	// Controller side pins
	input wire logic en,
	input wire logic txd,
	input wire logic txd_driven,
	output logic rxd,
	output logic reset_out_b,
	// Bus comparator and driver
	input wire logic bus_above_hi,
	input wire logic bus_below_lo,
	output logic bus_drive_dom,
	// Power and mode status
	output logic regulator_on,
	output lin_node_pkg::mode_t mode
);

	lin_node_pkg::ctl_state_t st_reg;
	lin_node_pkg::ctl_state_t st_next;
	logic txd_eff;
	logic reg_active;
	logic bus_active;
	logic en_fall;
	logic en_rise;

	////////////////////////////////////////////////////////////////////////////
	// Derived conditions

	// Open pin pulls up, so the bus stays recessive
	assign txd_eff = txd | ~txd_driven;
	assign reg_active = (st_reg.mode == lin_node_pkg::ST_INI) ||
		(st_reg.mode == lin_node_pkg::ST_NORMAL);
	// Driver only once the output clears the bus-enable level
	assign bus_active = reg_active & flags.vout_bus_ok;
	assign en_fall = st_reg.en_prev & ~en;
	assign en_rise = ~st_reg.en_prev & en;

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		st_next = st_reg;
		st_next.en_prev = en;

		// Mode sequencing; undervoltage outranks temperature
		if (flags.supply_uv) begin
			st_next.mode = lin_node_pkg::ST_POR;
		end else if (flags.over_temp) begin
			st_next.mode = lin_node_pkg::ST_TSD;
		end else begin
			unique case (st_reg.mode)
				lin_node_pkg::ST_POR: begin
					st_next.mode = lin_node_pkg::ST_INI;
				end
				lin_node_pkg::ST_TSD: begin
					st_next.mode = lin_node_pkg::ST_INI;
				end
				lin_node_pkg::ST_INI: begin
					// Enable level plays no part in power-up
					if (!flags.vout_low) begin
						st_next.mode = lin_node_pkg::ST_NORMAL;
					end
				end
				lin_node_pkg::ST_NORMAL: begin
					// Only a falling enable switches the regulator off
					if (en_fall) begin
						st_next.mode = lin_node_pkg::ST_SLEEP;
					end
				end
				lin_node_pkg::ST_SLEEP: begin
					if (en_rise || st_reg.wake_cnt == 8'(WAKE_CYCLES - 1)) begin
						st_next.mode = lin_node_pkg::ST_INI;
					end
				end
			endcase
		end

		// Bus wake filter; counts only in sleep, so shutdown ignores the bus
		if (st_reg.mode == lin_node_pkg::ST_SLEEP && !st_reg.bus_lvl) begin
			st_next.wake_cnt = st_reg.wake_cnt + 8'h01;
		end else begin
			st_next.wake_cnt = 8'h00;
		end

		// Driver follows transmit input, registered
		st_next.bus_dom = bus_active & ~txd_eff;

		// Comparator hysteresis; between thresholds the level holds
		if (bus_below_lo) begin
			st_next.bus_lvl = 1'b0;
		end else if (bus_above_hi) begin
			st_next.bus_lvl = 1'b1;
		end

		// Spike filter: a new level must persist the whole filter time
		if (st_reg.bus_lvl == st_reg.rxd) begin
			st_next.rx_cnt = 10'h000;
		end else if (st_reg.rx_cnt == 10'(RX_FILTER_CYCLES - 1)) begin
			st_next.rx_cnt = 10'h000;
			st_next.rxd = st_reg.bus_lvl;
		end else begin
			st_next.rx_cnt = st_reg.rx_cnt + 10'h001;
		end

		// Reset output timing
		st_next.rst_cnt = 24'h000000;
		st_next.rr_cnt = 16'h0000;
		if (!reg_active) begin
			// Regulator off: output is not good, hold reset now
			st_next.reset_b = 1'b0;
		end else if (st_reg.reset_b) begin
			if (flags.vout_low) begin
				if (st_reg.rr_cnt == 16'(RESET_REACTION_CYCLES - 1)) begin
					st_next.reset_b = 1'b0;
				end else begin
					st_next.rr_cnt = st_reg.rr_cnt + 16'h0001;
				end
			end
		end else if (!flags.vout_low) begin
			if (st_reg.rst_cnt == 24'(RESET_DELAY_CYCLES - 1)) begin
				st_next.reset_b = 1'b1;
			end else begin
				st_next.rst_cnt = st_reg.rst_cnt + 24'h000001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '{mode: lin_node_pkg::ST_POR, rst_cnt: 24'h000000,
				rr_cnt: 16'h0000, rx_cnt: 10'h000, wake_cnt: 8'h00,
				bus_lvl: 1'b1, rxd: 1'b1, bus_dom: 1'b0, en_prev: 1'b0,
				reset_b: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs
	assign rxd = st_reg.rxd;
	assign reset_out_b = st_reg.reset_b;
	assign bus_drive_dom = st_reg.bus_dom;
	assign regulator_on = reg_active;
	assign mode = st_reg.mode;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	sequence ok_supply_s;
		!flags.supply_uv && !flags.over_temp;
	endsequence

	sequence en_fall_in_normal_s;
		st_reg.mode == lin_node_pkg::ST_NORMAL && en_fall ##0 ok_supply_s;
	endsequence

	sequence sleep_s;
		st_reg.mode == lin_node_pkg::ST_SLEEP;
	endsequence

	por_entry_a: assert property (flags.supply_uv |=> mode == lin_node_pkg::ST_POR)
		else $error("undervoltage did not enter reset state");

	por_exit_a: assert property (mode == lin_node_pkg::ST_POR ##0 ok_supply_s
		|=> mode == lin_node_pkg::ST_INI)
		else $error("supply recovery did not start init");

	sleep_uv_a: assert property (sleep_s ##0 flags.supply_uv
		##1 ok_supply_s |=> mode == lin_node_pkg::ST_INI)
		else $error("undervoltage in sleep did not restart");

	tsd_entry_a: assert property (!flags.supply_uv && flags.over_temp
		|=> mode == lin_node_pkg::ST_TSD && !regulator_on
		##1 !reset_out_b && !bus_drive_dom)
		else $error("overtemperature did not shut down");

	tsd_exit_a: assert property (mode == lin_node_pkg::ST_TSD ##0 ok_supply_s
		|=> mode == lin_node_pkg::ST_INI)
		else $error("cooling did not rerun init");

	tsd_hold_a: assert property (mode == lin_node_pkg::ST_TSD && flags.over_temp
		&& !flags.supply_uv |=> mode == lin_node_pkg::ST_TSD)
		else $error("shutdown left while still hot");

	tx_block_a: assert property (bus_drive_dom |-> $past(bus_active)
		&& $past(flags.vout_bus_ok))
		else $error("transmit while blocked");

	tx_follow_a: assert property (bus_active && !txd && txd_driven
		|=> bus_drive_dom)
		else $error("low transmit did not drive dominant");

	tx_open_a: assert property (!txd_driven |=> !bus_drive_dom)
		else $error("open transmit input drove the bus");

	rx_filter_a: assert property ($changed(rxd)
		|-> $past(st_reg.rx_cnt) == 10'(RX_FILTER_CYCLES - 1))
		else $error("receive changed before filter time");

	rx_hyst_a: assert property (bus_below_lo |=> !st_reg.bus_lvl)
		else $error("bus low not recognised");

	reset_release_a: assert property ($rose(reset_out_b)
		|-> $past(st_reg.rst_cnt) == 24'(RESET_DELAY_CYCLES - 1))
		else $error("reset released early");

	reset_react_a: assert property ($fell(reset_out_b) && $past(regulator_on)
		|-> $past(st_reg.rr_cnt) == 16'(RESET_REACTION_CYCLES - 1))
		else $error("reset asserted without reaction delay");

	sleep_entry_a: assert property (en_fall_in_normal_s
		|=> mode == lin_node_pkg::ST_SLEEP && !regulator_on ##1 !bus_drive_dom)
		else $error("enable fall did not enter sleep");

	sleep_stay_a: assert property (sleep_s ##0 ok_supply_s ##0 !en ##0 st_reg.bus_lvl
		|=> mode == lin_node_pkg::ST_SLEEP)
		else $error("sleep left without bus activity");

	// Steady-state guards; reset and driver lag the mode by one cycle
	// because both are registered from the previous mode

	rx_high_a: assert property (bus_above_hi && !bus_below_lo
		|=> st_reg.bus_lvl)
		else $error("bus high not recognised");

	rx_hold_a: assert property (!bus_above_hi && !bus_below_lo
		|=> st_reg.bus_lvl == $past(st_reg.bus_lvl))
		else $error("bus level moved between thresholds");

	rx_steady_a: assert property (st_reg.bus_lvl == rxd
		|=> $stable(rxd))
		else $error("receive moved without a new bus level");

	sleep_quiet_a: assert property (sleep_s |-> !regulator_on
		##1 !bus_drive_dom && !reset_out_b)
		else $error("sleep left regulator or driver on");

	tsd_quiet_a: assert property (mode == lin_node_pkg::ST_TSD |-> !regulator_on
		##1 !bus_drive_dom && !reset_out_b)
		else $error("shutdown left regulator or driver on");

	bus_gate_a: assert property (!flags.vout_bus_ok
		|=> !bus_drive_dom)
		else $error("driver active below bus-enable level");

	uv_shutdown_a: assert property (flags.supply_uv |=> !regulator_on
		##1 !reset_out_b && !bus_drive_dom)
		else $error("undervoltage left regulator on");

	wake_bus_a: assert property (sleep_s ##0 ok_supply_s
		##0 st_reg.wake_cnt == 8'(WAKE_CYCLES - 1) |=> mode == lin_node_pkg::ST_INI)
		else $error("bus activity did not wake");

	normal_hold_a: assert property (mode == lin_node_pkg::ST_NORMAL && en
		##0 ok_supply_s |=> mode == lin_node_pkg::ST_NORMAL)
		else $error("normal mode left with enable high");

	ini_hold_a: assert property (mode == lin_node_pkg::ST_INI && flags.vout_low
		##0 ok_supply_s |=> mode == lin_node_pkg::ST_INI)
		else $error("init left with output low");

endmodule : lin_node_mode_and_reset_control

// ### inc/lin_node_map.svh
// Timing and reset constants for the LIN node mode and reset control
`ifndef LIN_NODE_MAP_SVH
`define LIN_NODE_MAP_SVH

// Core clock rate
`define LN_MCLK_MHZ 100

// Reset delay after the regulated output is good, in ms
`define LN_RESET_DELAY_MS 100
`define LN_RESET_DELAY_CYCLES (`LN_RESET_DELAY_MS * 1000 * `LN_MCLK_MHZ)

// Reset reaction delay, in us
`define LN_RESET_REACTION_DELAY_US 10
`define LN_RESET_REACTION_CYCLES (`LN_RESET_REACTION_DELAY_US * `LN_MCLK_MHZ)

// Receive spike filter time constant, in ns
`define LN_RX_FILTER_NS 2800
`define LN_RX_FILTER_CYCLES ((`LN_RX_FILTER_NS * `LN_MCLK_MHZ + 999) / 1000)

// Bus wake-up filter, in cycles
`define LN_WAKE_CYCLES 16

// Counter widths
`define LN_RST_CNT_W 24
`define LN_RR_CNT_W 16
`define LN_RX_CNT_W 10
`define LN_WAKE_CNT_W 8

`endif

// ### inc/lin_node_pkg.sv
// Types for the LIN node mode and reset control
package lin_node_pkg;

	// Operating states
	typedef enum logic [2:0] {
		ST_POR,
		ST_INI,
		ST_NORMAL,
		ST_SLEEP,
		ST_TSD
	} mode_t;

	// Synchronised comparator flags, hysteresis already applied
	typedef struct packed {
		logic supply_uv;
		logic vout_low;
		logic vout_bus_ok;
		logic over_temp;
	} supply_flags_t;

	// Whole state of the controller
	typedef struct packed {
		mode_t mode;
		logic [23:0] rst_cnt;
		logic [15:0] rr_cnt;
		logic [9:0] rx_cnt;
		logic [7:0] wake_cnt;
		logic bus_lvl;
		logic rxd;
		logic bus_dom;
		logic en_prev;
		logic reset_b;
	} ctl_state_t;

endpackage : lin_node_pkg

// ### sim/lin_bus_model.sv
// Behavioural LIN wire with the node's receive comparator pair
`timescale 1ns/1ps
module lin_bus_model (
	// Parties pulling the wire dominant
	node_dom,
	ext_dom,
	// Wire held between the two thresholds
	ext_mid,
	// Comparator flags towards the node
	bus_above_hi,
	bus_below_lo
);
	input wire logic node_dom;
	input wire logic ext_dom;
	input wire logic ext_mid;
	output logic bus_above_hi;
	output logic bus_below_lo;
	logic wire_low;
	// Wired-AND: any dominant puller beats the recessive pull-up
	assign wire_low = node_dom | ext_dom;
	// A mid-level wire sets neither flag; a dominant puller still wins
	assign bus_below_lo = wire_low;
	assign bus_above_hi = ~wire_low & ~ext_mid;
endmodule : lin_bus_model

// ### sim/lin_node_mode_and_reset_control_bench.sv
// Self-checking bench for the LIN node mode and reset control
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("wrong value t=%0t got %0h exp %0h", $time, a, b); end end
module lin_node_mode_and_reset_control_bench;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	lin_node_pkg::supply_flags_t flags = 4'h4;
	logic en = 1'b0;
	logic txd = 1'b1;
	logic txd_driven = 1'b1;
	logic ext_dom = 1'b0;
	logic ext_mid = 1'b0;
	logic rxd, reset_out_b, bus_above_hi, bus_below_lo, bus_drive_dom, regulator_on;
	lin_node_pkg::mode_t mode;
	int n_mismatch = 0;
	int num_checks = 0;

	////////////////////////////////////////////////////////////////////////////
	// Short counts keep the run small; expectations derive from these
	lin_node_mode_and_reset_control #(.RESET_DELAY_CYCLES(50), .RESET_REACTION_CYCLES(8),
		.RX_FILTER_CYCLES(4), .WAKE_CYCLES(16)) uut (.mclk(mclk), .rst_b(rst_b),
		.flags(flags), .en(en), .txd(txd), .txd_driven(txd_driven), .rxd(rxd),
		.reset_out_b(reset_out_b), .bus_above_hi(bus_above_hi),
		.bus_below_lo(bus_below_lo), .bus_drive_dom(bus_drive_dom),
		.regulator_on(regulator_on), .mode(mode));
	lin_bus_model bus (.node_dom(bus_drive_dom), .ext_dom(ext_dom), .ext_mid(ext_mid),
		.bus_above_hi(bus_above_hi), .bus_below_lo(bus_below_lo));

	// Clock, 10 ns period
	initial begin
		forever #5 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////////
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize

	task cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc

	// Bounded waits; running out ends the run
	task wait_mode(input lin_node_pkg::mode_t m, input int lim);
		for (int i = 0; i < lim && mode !== m; i++) @(negedge mclk);
		`CHK(mode, m)
		if (mode !== m) summarize();
	endtask : wait_mode

	task wait_rst(input logic v, input int lim);
		for (int i = 0; i < lim && reset_out_b !== v; i++) @(negedge mclk);
		`CHK(reset_out_b, v)
		if (reset_out_b !== v) summarize();
	endtask : wait_rst

	task wait_rx(input logic v, input int lim);
		for (int i = 0; i < lim && rxd !== v; i++) @(negedge mclk);
		`CHK(rxd, v)
		if (rxd !== v) summarize();
	endtask : wait_rx

	////////////////////////////////////////////////////////////////////////////
	task t_power;
		wait_mode(lin_node_pkg::ST_INI, 4);
		`CHK(regulator_on, 1'b1)
		cyc(3);
		`CHK(mode, lin_node_pkg::ST_INI)
		flags.vout_low = 1'b0;
		flags.vout_bus_ok = 1'b1;
		wait_mode(lin_node_pkg::ST_NORMAL, 3);
		cyc(46);
		`CHK(reset_out_b, 1'b0)
		wait_rst(1'b1, 8);
	endtask : t_power

	task t_tx;
		txd = 1'b0;
		cyc(1);
		`CHK(bus_drive_dom, 1'b1)
		wait_rx(1'b0, 10);
		txd = 1'b1;
		wait_rx(1'b1, 10);
		// A spike shorter than the filter must not reach rxd
		ext_dom = 1'b1;
		cyc(2);
		ext_dom = 1'b0;
		cyc(8);
		`CHK(rxd, 1'b1)
		// Between the thresholds the last level holds, low and high
		ext_mid = 1'b1;
		ext_dom = 1'b1;
		wait_rx(1'b0, 10);
		ext_dom = 1'b0;
		cyc(8);
		`CHK(rxd, 1'b0)
		ext_mid = 1'b0;
		wait_rx(1'b1, 10);
		ext_mid = 1'b1;
		cyc(8);
		`CHK(rxd, 1'b1)
		ext_mid = 1'b0;
		txd_driven = 1'b0;
		txd = 1'b0;
		cyc(2);
		`CHK(bus_drive_dom, 1'b0)
		txd_driven = 1'b1;
		flags.vout_bus_ok = 1'b0;
		cyc(2);
		`CHK(bus_drive_dom, 1'b0)
		flags.vout_bus_ok = 1'b1;
		cyc(2);
		`CHK(bus_drive_dom, 1'b1)
		txd = 1'b1;
		cyc(2);
	endtask : t_tx

	task t_react;
		flags.vout_low = 1'b1;
		cyc(3);
		flags.vout_low = 1'b0;
		cyc(10);
		`CHK(reset_out_b, 1'b1)
		flags.vout_low = 1'b1;
		cyc(6);
		`CHK(reset_out_b, 1'b1)
		wait_rst(1'b0, 6);
		flags.vout_low = 1'b0;
		wait_rst(1'b1, 60);
	endtask : t_react

	task t_sleep;
		en = 1'b1;
		txd = 1'b0;
		cyc(2);
		`CHK(mode, lin_node_pkg::ST_NORMAL)
		en = 1'b0;
		wait_mode(lin_node_pkg::ST_SLEEP, 3);
		cyc(2);
		`CHK(regulator_on, 1'b0)
		`CHK(bus_drive_dom, 1'b0)
		txd = 1'b1;
		ext_dom = 1'b1;
		wait_mode(lin_node_pkg::ST_INI, 25);
		ext_dom = 1'b0;
		wait_mode(lin_node_pkg::ST_NORMAL, 3);
		wait_rst(1'b1, 60);
	endtask : t_sleep

	task t_perm;
		en = 1'b1;
		for (int i = 0; i < 60; i++) begin
			ext_dom = i[2];
			cyc(1);
			`CHK(mode, lin_node_pkg::ST_NORMAL)
		end
		ext_dom = 1'b0;
	endtask : t_perm

	task t_therm;
		flags.over_temp = 1'b1;
		txd = 1'b0;
		wait_mode(lin_node_pkg::ST_TSD, 3);
		cyc(2);
		`CHK(regulator_on, 1'b0)
		`CHK(bus_drive_dom, 1'b0)
		`CHK(reset_out_b, 1'b0)
		en = 1'b0;
		cyc(2);
		en = 1'b1;
		ext_dom = 1'b1;
		cyc(20);
		ext_dom = 1'b0;
		`CHK(mode, lin_node_pkg::ST_TSD)
		txd = 1'b1;
		flags.over_temp = 1'b0;
		wait_mode(lin_node_pkg::ST_NORMAL, 4);
		wait_rst(1'b1, 60);
	endtask : t_therm

	task t_uv;
		en = 1'b0;
		wait_mode(lin_node_pkg::ST_SLEEP, 3);
		flags.supply_uv = 1'b1;
		wait_mode(lin_node_pkg::ST_POR, 3);
		`CHK(regulator_on, 1'b0)
		flags.supply_uv = 1'b0;
		wait_mode(lin_node_pkg::ST_INI, 2);
		wait_mode(lin_node_pkg::ST_NORMAL, 3);
	endtask : t_uv

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		cyc(2);
		rst_b = 1'b1;
		t_power();
		t_tx();
		t_react();
		t_sleep();
		t_perm();
		t_therm();
		t_uv();
		summarize();
	end
endmodule : lin_node_mode_and_reset_control_bench
